/* File: hpm_asserts.sv */
// Purpose: Port checks for the host port pin mux
// Assumes: Shadow copies of ctrl, dir and gp out follow bus writes
// Notes: Bound to hpm_top by the statement after the module
`timescale 1ns/1ps
module hpm_asserts (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic stop_mode_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   input wire logic [12:0] pin_in,
   input wire logic host_chip_select_in,
   input wire logic [12:0] pin_out,
   input wire logic [12:0] pin_oe_out,
   input wire logic host_access_out
);
   logic [5:0] ctl;
   logic [12:0] dir;
   logic [12:0] gpo;
   wire cs_act = host_chip_select_in ^ ctl[hpm_pkg::CTL_CS_POL];
   wire hn = ctl[0] & ~ctl[1];
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ==========================
   // Shadow registers from bus writes
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ctl <= hpm_pkg::CTL_RESET;
         dir <= hpm_pkg::DIR_RESET;
         gpo <= 13'h0000;
      end
      else if (reg_wr_in)
      begin
         if (reg_addr_in == hpm_pkg::OFF_CTRL) ctl <= reg_wdata_in[5:0];
         if (reg_addr_in == hpm_pkg::OFF_DIR) dir <= reg_wdata_in[12:0];
         if (reg_addr_in == hpm_pkg::OFF_GPOUT) gpo <= reg_wdata_in[12:0];
      end
   end
   // Checks
   rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside answer cycle");
   rd_ctrl_a: assert property (reg_rd_in && reg_addr_in == hpm_pkg::OFF_CTRL
      |=> reg_rdata_out == {10'h000, $past(ctl)}) else $error("ctrl readback");
   stop_off_a: assert property ($past(stop_mode_in) |-> pin_oe_out == 13'h0000)
      else $error("pin driven in stop");
   gp_dir_a: assert property ($past(!ctl[0] && !stop_mode_in) |-> pin_oe_out == $past(dir))
      else $error("gp direction");
   gp_out_a: assert property ($past(!ctl[0] && !stop_mode_in)
      |-> (pin_out & pin_oe_out) == ($past(gpo) & pin_oe_out)) else $error("gp level");
   host_in_a: assert property (ctl[0] |=> pin_oe_out[12:8] == 5'h00)
      else $error("host control pin driven");
   cs_gate_a: assert property ((hn && !cs_act)[*5]
      |-> pin_oe_out[7:0] == 8'h00 && !host_access_out) else $error("strobe without select");
   pulse_one_a: assert property (host_access_out |=> !host_access_out)
      else $error("access pulse too long");
   cover property (hn ##1 host_access_out);
   cover property (ctl[1] && host_access_out);
   cover property (stop_mode_in ##1 !stop_mode_in);
endmodule // hpm_asserts
bind hpm_top hpm_asserts chk_u (.*);

/* File: hpm_host_model.sv */
// Purpose: External host bus and pin pull model
// Assumes: One polarity for address, data strobes and select
// Notes: Undriven pins toggle every cycle
`timescale 1ns/1ps
module hpm_host_model (
   input wire logic clk_in,
   input wire logic [12:0] pin_out,
   input wire logic [12:0] pin_oe_out,
   output logic [12:0] pin_in,
   output logic host_chip_select_in
);
   logic [12:0] drv = 13'h0000;
   logic [12:0] oe = 13'h0000;
   logic tog = 1'b0;
   logic pol = 1'b0;
   logic cs_on = 1'b0;
   logic cs_off = 1'b0;
   // ==========================
   // Wire level: device, then host, else a moving pattern
   assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & oe & drv)
      | (~pin_oe_out & ~oe & {13{tog}});
   assign host_chip_select_in = (cs_on & ~cs_off) ? ~pol : pol;
   always @(posedge clk_in) tog <= ~tog;
   // One host transfer, strobes held well past the synchronizer
   task automatic xfer(input logic mux, input logic dbl, input logic rd,
      input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [1:0] idle;
      idle = dbl ? {pol, pol} : {pol, rd};
      @(posedge clk_in);
      cs_on <= 1'b1;
      oe <= 13'h1FFF;
      drv <= mux ? {idle, a[9:8], ~pol, a[7:0]} : {idle, a[2:0], d};
      if (mux)
      begin
         repeat (4) @(posedge clk_in);
         drv <= {idle, a[9:8], pol, d};
      end
      repeat (4) @(posedge clk_in);
      oe[7:0] <= {8{~rd}};
      drv[12:11] <= dbl ? (rd ? {pol, ~pol} : {~pol, pol}) : {~pol, rd};
      repeat (6) @(posedge clk_in);
      q = pin_in[7:0];
      drv[12:11] <= idle;
      repeat (4) @(posedge clk_in);
      oe <= 13'h1F00;
      cs_on <= 1'b0;
   endtask
endmodule // hpm_host_model

/* File: hpm_pkg.sv */
// Purpose: Shared constants for the host port pin function mux
// Assumes: Registers reached over a plain address/strobe port
// Notes: Offsets are word indices on the plain register port
package hpm_pkg;
   localparam int PORT_BITS = 13;
   localparam int LOW_BITS = 8;
   localparam int ADDR_W = 4;
   // ======================================================
   // Register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_DIR = 4'h1;
   localparam logic [3:0] OFF_GPOUT = 4'h2;
   localparam logic [3:0] OFF_GPIN = 4'h3;
   localparam logic [3:0] OFF_HADDR = 4'h4;
   localparam logic [3:0] OFF_HDATA = 4'h5;
   localparam logic [3:0] OFF_HSTAT = 4'h6;
   localparam logic [3:0] OFF_HRDATA = 4'h7;
   // ======================================================
   // Port control register fields
   localparam int CTL_HOST_EN = 0;
   localparam int CTL_MUX = 1;
   localparam int CTL_DSTROBE = 2;
   localparam int CTL_AS_POL = 3;
   localparam int CTL_DS_POL = 4;
   localparam int CTL_CS_POL = 5;
   localparam int CTL_W = 6;
   localparam logic [5:0] CTL_RESET = 6'h00;
   localparam logic [12:0] DIR_RESET = 13'h0000;
   // Status fields
   localparam int ST_RD = 0;
   localparam int ST_WR = 1;
   localparam int SYNC_STAGES = 2;
endpackage

/* File: hpm_strobe_if.sv */
// Purpose: Carries synchronized strobe levels between modules
// Assumes: Single clock domain
// Notes: Strobes are active high after polarity handling
`timescale 1ns/1ps
interface hpm_strobe_if;
   logic raw;
   logic pol;
   logic level;
   modport sync_side (input raw, input pol, output level);
   modport user_side (output raw, output pol, input level);
endinterface // hpm_strobe_if

/* File: hpm_strobe_sync.sv */
// Purpose: Polarity correction and two-flop synchronizer for one strobe
// Assumes: Pin level stable enough for a two-stage synchronizer
// Notes: Output active high, polarity bit high means active-low pin
`timescale 1ns/1ps
module hpm_strobe_sync #(
   parameter int STAGES = hpm_pkg::SYNC_STAGES
)(
   input wire logic clk_in,
   input wire logic rst_in,
   hpm_strobe_if.sync_side s
);
   initial
   begin
      if (STAGES < 2) $error("hpm_strobe_sync needs two stages");
   end
   logic [STAGES-1:0] pipe;
   wire logic corrected = s.raw ^ s.pol;
   // ======================================================
   // Synchronizer chain
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         pipe <= '0;
      else
         pipe <= {pipe[STAGES-2:0], corrected};
   end
   assign s.level = pipe[STAGES-1];
endmodule // hpm_strobe_sync

/* File: hpm_tb.sv */
// Purpose: Self-checking bench for the host port pin mux
// Assumes: Host model on the pins, checker bound to the top
// Notes: Random values from a fixed seed
`timescale 1ns/1ps
module tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic stop_mode_in = 1'b0;
   logic [3:0] reg_addr_in = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] reg_rdata_out;
   logic [12:0] pin_in;
   logic host_chip_select_in;
   logic [12:0] pin_out;
   logic [12:0] pin_oe_out;
   logic host_access_out;
   int failures = 0;
   int checks_done = 0;
   int acc_seen = 0;
   int acc_base = 0;
   integer seed = 32'h7e3d1d97;
   logic [15:0] v, q, w;
   logic [9:0] a;
   logic [7:0] d8, r8, hq;
   always #12.5 clk_in = ~clk_in;
   hpm_top dut_u (.*);
   hpm_host_model host_u (.*);
   // Count host access pulses seen on the port
   always @(posedge clk_in)
   begin
      if (host_access_out === 1'b1)
         acc_seen <= acc_seen + 1;
   end
   // Expected latched host address for each bus style
   function automatic logic [15:0] exp_addr(input logic mux, input logic [9:0] ad);
      exp_addr = mux ? {6'h00, ad} : {13'h0000, ad[2:0]};
   endfunction
   // ==========================
   // Compare, bus and mode tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [15:0] d);
      @(posedge clk_in);
      reg_addr_in <= ad;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      d = reg_rdata_out;
   endtask
   task automatic rc(input logic [3:0] ad, input logic [15:0] exp);
      logic [15:0] d;
      rd(ad, d);
      chk(d, exp);
   endtask
   task automatic mode(input logic [5:0] c);
      wr(hpm_pkg::OFF_CTRL, 16'h0000);
      host_u.pol <= c[5];
      host_u.drv <= {{2{c[5]}}, 2'h0, c[5], 8'h00};
      host_u.oe <= 13'h1F00;
      wr(hpm_pkg::OFF_CTRL, {10'h000, c});
      repeat (6) @(posedge clk_in);
      wr(hpm_pkg::OFF_HSTAT, 16'h0003);
   endtask
   task automatic end_sim;
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #500000;
      failures++;
      end_sim;
   end
   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rc(hpm_pkg::OFF_CTRL, 16'h0000);
      rc(hpm_pkg::OFF_DIR, 16'h0000);
      wr(4'h9, 16'hFFFF);
      rc(4'h9, 16'h0000);
      host_u.oe <= 13'h1FFF;
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 16'h1FFF : $random(seed);
         q = $random(seed);
         host_u.drv <= $random(seed);
         wr(hpm_pkg::OFF_DIR, {3'h0, v[12:0]});
         wr(hpm_pkg::OFF_GPOUT, q);
         repeat (3) @(posedge clk_in);
         chk({3'h0, pin_oe_out}, {3'h0, v[12:0]});
         chk({3'h0, pin_out & v[12:0]}, {3'h0, q[12:0] & v[12:0]});
         rd(hpm_pkg::OFF_GPIN, w);
         chk(w & {3'h0, ~v[12:0]}, {3'h0, ~v[12:0] & host_u.drv});
      end
      // Stop mode: no drive and a frozen input sample
      @(posedge clk_in);
      stop_mode_in <= 1'b1;
      host_u.drv <= ~host_u.drv;
      repeat (3) @(posedge clk_in);
      chk({3'h0, pin_oe_out}, 16'h0000);
      rc(hpm_pkg::OFF_GPIN, w);
      @(posedge clk_in);
      stop_mode_in <= 1'b0;
      wr(hpm_pkg::OFF_DIR, 16'h0000);
      // Every bus style, random polarity, write then read
      for (int m = 0; m < 4; m++)
      begin
         r8 = $random(seed);
         a = $random(seed);
         d8 = $random(seed);
         mode({{3{r8[0]}}, m[1], m[0], 1'b1});
         acc_base = acc_seen;
         host_u.xfer(m[0], m[1], 1'b0, a, d8, hq);
         rc(hpm_pkg::OFF_HDATA, {8'h00, d8});
         rc(hpm_pkg::OFF_HADDR, exp_addr(m[0], a));
         rc(hpm_pkg::OFF_HSTAT, 16'h0002);
         chk(16'(acc_seen - acc_base), 16'h0001);
         wr(hpm_pkg::OFF_HSTAT, 16'h0003);
         wr(hpm_pkg::OFF_HRDATA, {8'h00, ~d8});
         acc_base = acc_seen;
         host_u.xfer(m[0], m[1], 1'b1, a, d8, hq);
         chk({8'h00, hq}, {8'h00, ~d8});
         rc(hpm_pkg::OFF_HSTAT, 16'h0001);
         chk(16'(acc_seen - acc_base), 16'h0001);
      end
      // Strobes ignored without chip select
      mode(6'h01);
      host_u.cs_off <= 1'b1;
      acc_base = acc_seen;
      host_u.xfer(1'b0, 1'b0, 1'b0, 10'h005, 8'h3C, hq);
      rc(hpm_pkg::OFF_HSTAT, 16'h0000);
      chk(16'(acc_seen - acc_base), 16'h0000);
      end_sim;
   end
endmodule // tb

/* File: hpm_top.sv */
// Purpose: Host port pin function mux with host bus slave and GPIO
// Assumes: Pin inputs synchronous except strobes, which are synchronized
// Assumes: Host holds each strobe and its data for three clock cycles
// Notes: Pins 0-7 data/addr-data, 8-12 address, strobe and rw pins
// Notes: Host edges are ignored for a few cycles after a control write
// Notes: Only the data pins ever drive in host mode
`timescale 1ns/1ps
module hpm_top #(
   parameter int PORT_BITS = hpm_pkg::PORT_BITS
)(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic stop_mode_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   input wire logic [12:0] pin_in,
   input wire logic host_chip_select_in,
   output logic [12:0] pin_out,
   output logic [12:0] pin_oe_out,
   output logic host_access_out
);
   // Cycles during which host strobes are ignored after a control write
   localparam int SETTLE_CYCLES = hpm_pkg::SYNC_STAGES + 2;
   initial
   begin
      if (PORT_BITS != 13) $error("hpm_top supports exactly 13 port pins");
      if (hpm_pkg::SYNC_STAGES < 2) $error("hpm_top needs two synchronizer stages");
      if (hpm_pkg::LOW_BITS != 8) $error("hpm_top expects an 8-bit host data bus");
      if (hpm_pkg::CTL_W != 6) $error("hpm_top expects a 6-bit control field");
      if (hpm_pkg::CTL_CS_POL >= hpm_pkg::CTL_W) $error("polarity bit outside control field");
      if (SETTLE_CYCLES <= hpm_pkg::SYNC_STAGES) $error("settle span shorter than the chain");
      if (SETTLE_CYCLES > 7) $error("settle span exceeds its counter");
   end

   // ======================================================
   // Control state
   // Software-set registers, host-captured values and strobe history
   logic [5:0] port_control_reg;
   logic [12:0] pin_direction_reg;
   logic [12:0] gp_out_reg;
   logic [12:0] gp_in_reg;
   logic [10:0] host_addr_reg;
   logic [7:0] host_rdata_reg;
   logic [7:0] host_wdata_reg;
   logic [1:0] host_stat_reg;
   logic host_data_drive;
   logic rs_prev;
   logic ws_prev;
   logic as_prev;

   // Function decode
   // Host enable off means every pin is general-purpose I/O; the mux
   // and strobe bits only matter while host enable is set
   wire logic host_mode = port_control_reg[hpm_pkg::CTL_HOST_EN];
   wire logic mux_mode = port_control_reg[hpm_pkg::CTL_MUX];
   wire logic dbl_strobe = port_control_reg[hpm_pkg::CTL_DSTROBE];
   wire logic gp_mode = !host_mode;

   // Pin map by mode
   //    pin    gp mode    host non-mux     host mux
   //    0-7    bits 0-7   data 0-7         address/data 0-7
   //    8      bit 8      address 0        address strobe
   //    9      bit 9      address 1        address 8
   //    10     bit 10     address 2        address 9
   //    11     bit 11     rw or read strobe (single or double strobe)
   //    12     bit 12     data or write strobe (single or double strobe)
   // Chip select pin is used only by the non-mux host bus

   // ======================================================
   // Strobe synchronizers
   // Four strobe-like pins share one synchronizer design. Each pin is
   // first made active high by its polarity bit, then passed through
   // the two-flop chain, so every later decision uses a clean,
   // clock-aligned level. The read and write strobes of the double
   // strobe bus share the data strobe polarity bit. Pin 11 also feeds
   // its chain in single strobe mode, where it is the rw level and
   // its synchronized copy is simply not used.
   hpm_strobe_if as_if ();
   hpm_strobe_if ds_if ();
   hpm_strobe_if ws_if ();
   hpm_strobe_if cs_if ();
   assign as_if.raw = pin_in[8];
   assign as_if.pol = port_control_reg[hpm_pkg::CTL_AS_POL];
   assign ds_if.raw = pin_in[12];
   assign ds_if.pol = port_control_reg[hpm_pkg::CTL_DS_POL];
   assign ws_if.raw = pin_in[11];
   assign ws_if.pol = port_control_reg[hpm_pkg::CTL_DS_POL];
   assign cs_if.raw = host_chip_select_in;
   assign cs_if.pol = port_control_reg[hpm_pkg::CTL_CS_POL];

   hpm_strobe_sync u_as (.clk_in(clk_in), .rst_in(rst_in), .s(as_if));
   hpm_strobe_sync u_ds (.clk_in(clk_in), .rst_in(rst_in), .s(ds_if));
   hpm_strobe_sync u_rs (.clk_in(clk_in), .rst_in(rst_in), .s(ws_if));
   hpm_strobe_sync u_cs (.clk_in(clk_in), .rst_in(rst_in), .s(cs_if));

   // ======================================================
   // Settle guard after a control write
   // A control write can flip a strobe polarity or the pin function,
   // which moves the synchronized levels while the host does nothing.
   // Host edges stay masked until the chains have refilled.
   logic [2:0] settle_cnt;
   wire logic ctrl_write = reg_wr_in && reg_addr_in == hpm_pkg::OFF_CTRL;
   wire logic settled = (settle_cnt == 3'h0);
   // Counter reloads on every control write
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         settle_cnt <= 3'(SETTLE_CYCLES);
      else if (ctrl_write)
         settle_cnt <= 3'(SETTLE_CYCLES);
      else if (!settled)
         settle_cnt <= settle_cnt - 3'h1;
   end

   // Chip select counts only in non-mux mode
   wire logic cs_ok = mux_mode | cs_if.level;
   wire logic host_live = host_mode & !stop_mode_in & settled;
   // Latency: a pin change reaches the level outputs two edges later,
   // the edge detectors one more, so a strobe must stay for three
   // cycles and write data must stay that long after the strobe ends.
   // Single strobe: pin 12 strobe, pin 11 level selects read
   wire logic rw_is_read = pin_in[11];
   wire logic single_act = ds_if.level & cs_ok & !dbl_strobe;
   wire logic rd_act = dbl_strobe ? (ws_if.level & cs_ok) : (single_act & rw_is_read);
   wire logic wr_act = dbl_strobe ? (ds_if.level & cs_ok) : (single_act & !rw_is_read);
   wire logic rd_rise = host_live & rd_act & !rs_prev;
   wire logic wr_fall = host_live & !wr_act & ws_prev;
   wire logic as_rise = host_live & mux_mode & as_if.level & !as_prev;

   // ======================================================
   // Address decode from pins
   // Non-mux mode takes three address bits from pins 8 to 10. Mux
   // mode takes the low byte from the shared bus and two upper bits
   // from pins 9 and 10; the top address bit is not wired and stays 0.
   wire logic [2:0] nonmux_addr = pin_in[10:8];
   wire logic [1:0] mux_upper = pin_in[10:9];
   wire logic [10:0] next_host_addr =
      mux_mode ? {1'b0, mux_upper, pin_in[7:0]} : {8'h00, nonmux_addr};

   // ======================================================
   // Pin drive selection
   // Stop mode wins over every function: nothing drives, so a pin
   // held by the board cannot fight the port while clocks are low.
   // General-purpose mode drives the pins whose direction bit is set.
   // Host mode drives only the data pins, and only during a read.
   logic [12:0] next_pin_out;
   logic [12:0] next_pin_oe;
   always_comb
   begin
      next_pin_out = '0;
      next_pin_oe = '0;
      if (stop_mode_in)
      begin
         next_pin_out = '0;
         next_pin_oe = '0;
      end
      else if (gp_mode)
      begin
         next_pin_out = gp_out_reg;
         next_pin_oe = pin_direction_reg;
      end
      else
      begin
         next_pin_out[7:0] = host_rdata_reg;
         next_pin_oe[7:0] = {8{host_data_drive}};
      end
   end

   // Drive enabled while a read strobe is active
   // The data pins turn around only under a read strobe, so a host
   // that drives during a write never meets the port driving
   wire logic next_drive = host_live & rd_act;

   // ======================================================
   // Pin registers and host transfer tracking
   // The previous levels track the strobes in every mode, also while
   // host edges are masked, so that no stale level makes a false edge
   // when the mask lifts.
   // The access pulse marks the opening edge of a read, when data must
   // be ready, and the closing edge of a write, when the byte is
   // complete.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pin_out <= '0;
         pin_oe_out <= '0;
         host_data_drive <= 1'b0;
         rs_prev <= 1'b0;
         ws_prev <= 1'b0;
         as_prev <= 1'b0;
         host_access_out <= 1'b0;
      end
      else
      begin
         pin_out <= next_pin_out;
         pin_oe_out <= next_pin_oe;
         host_data_drive <= next_drive;
         rs_prev <= rd_act;
         ws_prev <= wr_act;
         as_prev <= as_if.level;
         host_access_out <= rd_rise | wr_fall;
      end
   end

   // ======================================================
   // Host address, data and status capture
   // The address is taken when the transfer opens: on the address
   // strobe in mux mode, else on the first edge of a read or write
   // strobe. Write data are taken when the write strobe closes, the
   // point at which a host bus guarantees them valid.
   // Transfer opening in non-mux mode, and status clear strobes
   wire logic open_nonmux = host_live & !mux_mode & (rd_rise | (wr_act & !ws_prev));
   wire logic wr_stat = reg_wr_in && reg_addr_in == hpm_pkg::OFF_HSTAT;
   wire logic clr_rd = wr_stat & reg_wdata_in[hpm_pkg::ST_RD];
   wire logic clr_wr = wr_stat & reg_wdata_in[hpm_pkg::ST_WR];
   // Capture registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         host_addr_reg <= '0;
         host_wdata_reg <= '0;
         host_stat_reg <= '0;
      end
      else
      begin
         if (as_rise)
            host_addr_reg <= next_host_addr;
         else if (open_nonmux)
            host_addr_reg <= next_host_addr;
         if (wr_fall)
            host_wdata_reg <= pin_in[7:0];
         // Set wins over the software clear, so an access that lands
         // in the clearing cycle is never lost
         if (rd_rise)
            host_stat_reg[hpm_pkg::ST_RD] <= 1'b1;
         else if (clr_rd)
            host_stat_reg[hpm_pkg::ST_RD] <= 1'b0;
         if (wr_fall)
            host_stat_reg[hpm_pkg::ST_WR] <= 1'b1;
         else if (clr_wr)
            host_stat_reg[hpm_pkg::ST_WR] <= 1'b0;
      end
   end

   // ======================================================
   // GPIO input sampling, frozen during stop
   // Levels are sampled every cycle in general-purpose mode and held
   // in stop, so software reads the last level seen before stop
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         gp_in_reg <= '0;
      else if (!stop_mode_in && gp_mode)
         gp_in_reg <= pin_in;
   end

   // ======================================================
   // Register writes
   // Register map, word offsets on the plain port
   //    0  control: host enable, mux, double strobe, three polarities
   //    1  direction, one bit per pin, high drives
   //    2  general-purpose output levels
   //    3  general-purpose input levels, frozen in stop (read only)
   //    4  last host address (read only)
   //    5  last byte written by the host (read only)
   //    6  host read and write flags, write one to clear
   //    7  byte driven to the host on its reads
   wire logic wr_ctrl = reg_wr_in && reg_addr_in == hpm_pkg::OFF_CTRL;
   wire logic wr_dir = reg_wr_in && reg_addr_in == hpm_pkg::OFF_DIR;
   wire logic wr_gpo = reg_wr_in && reg_addr_in == hpm_pkg::OFF_GPOUT;
   wire logic wr_hrd = reg_wr_in && reg_addr_in == hpm_pkg::OFF_HRDATA;
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         port_control_reg <= hpm_pkg::CTL_RESET;
         pin_direction_reg <= hpm_pkg::DIR_RESET;
         gp_out_reg <= '0;
         host_rdata_reg <= '0;
      end
      else
      begin
         if (wr_ctrl)
            port_control_reg <= reg_wdata_in[5:0];
         if (wr_dir)
            pin_direction_reg <= reg_wdata_in[12:0];
         if (wr_gpo)
            gp_out_reg <= reg_wdata_in[12:0];
         if (wr_hrd)
            host_rdata_reg <= reg_wdata_in[7:0];
      end
   end

   // ======================================================
   // Read mux, data in the cycle after the strobe
   // Read data are registered, so they stand in the cycle after the
   // read strobe only and are zero otherwise; software samples one cycle later
   logic [15:0] next_rdata;
   always_comb
   begin
      next_rdata = 16'h0000;
      case (reg_addr_in)
         hpm_pkg::OFF_CTRL: next_rdata = {10'h000, port_control_reg};
         hpm_pkg::OFF_DIR: next_rdata = {3'h0, pin_direction_reg};
         hpm_pkg::OFF_GPOUT: next_rdata = {3'h0, gp_out_reg};
         hpm_pkg::OFF_GPIN: next_rdata = {3'h0, gp_in_reg};
         hpm_pkg::OFF_HADDR: next_rdata = {5'h00, host_addr_reg};
         hpm_pkg::OFF_HDATA: next_rdata = {8'h00, host_wdata_reg};
         hpm_pkg::OFF_HSTAT: next_rdata = {14'h0000, host_stat_reg};
         hpm_pkg::OFF_HRDATA: next_rdata = {8'h00, host_rdata_reg};
         default: next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         reg_rdata_out <= 16'h0000;
      else if (reg_rd_in)
         reg_rdata_out <= next_rdata;
      else
         reg_rdata_out <= 16'h0000;
   end
endmodule // hpm_top
